// >>> logic/pll_branch_ctrl.sv
// Multiplier branch, USB clock branch and secondary oscillator control
//
// Contract
// R1: Basic variant multiplies its input by four; primary or fast RC may feed it.
// R2: A change of multiplier source restarts the ready timer; output gated until done.
// R3: USB variant turns a 4 MHz reference into a 96 MHz rate, factor 24.
// R4: USB branch is a fixed divide by two, always 48 MHz.
// R5: System branch divides by three, then by the selectable divider.
// R6: Software sets the input divide field so the prescaler yields 4 MHz.
// R7: Input divide codes select 1,2,3,4,5,6,10,12.
// R8: Software uses only the listed input frequencies for USB.
// R9: System divide field gives 32,16,8,4 MHz; instruction rate is half.
// R10: With USB active software picks only the 32 or 16 MHz setting.
// R11: System clock choices do not depend on the input divide field.
// R12: Only primary multiplied modes clock the USB branch.
// R13: Software keeps the system clock at or below 32 MHz.
// R14: Fast RC plus multiplier should not clock USB.
// R15: Read-only lock flag at bit 5 sets after the lock delay.
// R16: Lock clears at reset, on switches to multiplier modes, and stays clear otherwise.
// R17: Lock flag is a timer only; it never sees a real loss of lock.
// R18: Setting the enable bit runs the secondary oscillator and claims its pins.
// R19: Software unlocks before writing the control register; other writes are ignored.
// R20: With enable set the secondary oscillator runs continuously.
// R21: With enable clear it runs only while current field is 100.
// R22: With enable clear, secondary selected and sleep, the oscillator stops.
// R23: Fast RC multiplied mode is code 001, valid only with postscale 000 or 001.
// R24: Ready interval and lock delay are parameters.
`timescale 1ns/1ps
module pll_branch_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter bit       USB_VARIANT = 1'b1,
  parameter osc_sel_t INIT_OSC    = OSC_FAST_RC,
  parameter int       READY_NS    = READY_NS_DEF,
  parameter int       LOCK_NS     = LOCK_NS_DEF
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              PRI_OSC_IN,
  input  wire logic              FRC_OSC_IN,
  input  wire logic              SLEEP,
  output logic                   SECONDARY_32K_OSC_RUN,
  output logic                   SECONDARY_32K_OSC_PINS_OWNED,
  output logic                   MULT_CLK_EN,
  output logic                   USB_CLK_EN,
  output logic                   SYS_CLK_EN,
  output logic                   INSTR_CLK_EN,
  output logic                   LOCK,
  output logic                   MULT_READY
);
  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int READY_CYC_I = (READY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYC_I  = (LOCK_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int READY_CYC   = (READY_CYC_I < 1) ? 1 : READY_CYC_I;
  localparam int LOCK_CYC    = (LOCK_CYC_I < 1) ? 1 : LOCK_CYC_I;

  if (READY_CYC >= (1 << TIMER_W) || LOCK_CYC >= (1 << TIMER_W)) begin : g_chk
    $error("Ready or lock interval exceeds timer width");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        pri_s1_r, pri_s2_r, pri_s3_r;
  logic        frc_s1_r, frc_s2_r, frc_s3_r;
  osc_sel_t    cur_osc_r, cur_osc_nxt;
  logic [2:0]  new_osc_r, new_osc_nxt;
  logic        lposc_en_r, lposc_en_nxt;
  cfg_t        cfg_r, cfg_nxt;
  logic        key_seen_r, key_seen_nxt;
  logic        unlocked_r, unlocked_nxt;
  logic        lock_nxt;
  mult_src_t   src_r, src_now;
  logic [5:0]  pend_r, pend_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic        instr_ph_r, instr_ph_nxt;
  logic        secondary_32k_osc_run_nxt, mult_en_nxt, usb_en_nxt, sys_en_nxt, instr_en_nxt;

  logic        pri_edge, frc_edge, mult_in_edge, ref_tick, mult_raw, mult_tick;
  logic        pre_pulse, usb_pulse, div3_pulse, sysdiv_pulse, sys_tick;
  logic        ready_done, lock_done, restart, sw_to_mult, osc_wr;

  // Pin edges only read the second and third stages
  assign pri_edge = pri_s2_r & ~pri_s3_r;
  assign frc_edge = frc_s2_r & ~frc_s3_r;
  assign osc_wr   = WR && ADDR == OFF_OSC_CTRL && unlocked_r; // R19

  // ----------------------------------------------------------------
  // Multiplier source and timers
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cur_osc_r)
      OSC_FAST_RC_MULT: src_now = (cfg_r.fast_rc_postscale_sel <= 3'b001) ? SRC_FAST_RC
                                                                           : SRC_NONE; // R23
      OSC_PRIMARY_MULT: src_now = SRC_PRIMARY; // R1
      default:          src_now = SRC_NONE;
    endcase
  end

  assign sw_to_mult = osc_wr && WDATA[SWITCH_BIT] &&
                      (WDATA[NEW_OSC_LSB +: 3] == OSC_FAST_RC_MULT ||
                       WDATA[NEW_OSC_LSB +: 3] == OSC_PRIMARY_MULT);
  assign restart    = sw_to_mult || (src_now != src_r); // R2

  interval_timer #(.W(TIMER_W)) u_ready (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .restart (restart),
    .limit   (TIMER_W'(READY_CYC)), // R24
    .done    (ready_done)
  );

  interval_timer #(.W(TIMER_W)) u_lock (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .restart (restart),
    .limit   (TIMER_W'(LOCK_CYC)), // R24
    .done    (lock_done)
  );

  // ----------------------------------------------------------------
  // Multiplier pulse chain
  // ----------------------------------------------------------------
  always_comb begin
    unique case (src_r)
      SRC_PRIMARY: mult_in_edge = pri_edge;
      SRC_FAST_RC: mult_in_edge = frc_edge;
      default:     mult_in_edge = 1'b0;
    endcase
  end

  // Prescaler ratio comes only from the input divide field
  pulse_divider #(.W(4)) u_prescale (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en_in (mult_in_edge),
    .ratio (prescale_ratio(cfg_r.mult_input_divide_sel)), // R7
    .pulse (pre_pulse)
  );

  assign ref_tick = USB_VARIANT ? pre_pulse : mult_in_edge;

  // Each reference edge queues FACTOR output ticks, one released per cycle;
  // the input period must span at least FACTOR system cycles
  always_comb begin
    pend_nxt = pend_r - {5'h00, (pend_r != 6'h00)};
    if (ref_tick) begin
      pend_nxt = pend_nxt + (USB_VARIANT ? USB_FACTOR : BASIC_FACTOR); // R1 R3
    end
  end

  assign mult_raw  = (pend_r != 6'h00);
  // A restart blocks the cycle in which it happens, before the timer's done drops
  assign mult_tick = mult_raw && ready_done && !restart; // R2

  pulse_divider #(.W(2)) u_usb_div (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en_in (mult_tick),
    .ratio (USB_BRANCH_DIV), // R4
    .pulse (usb_pulse)
  );

  pulse_divider #(.W(2)) u_sys_div3 (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en_in (mult_tick),
    .ratio (SYS_BRANCH_DIV), // R5
    .pulse (div3_pulse)
  );

  // Divider choice never looks at the prescale field
  pulse_divider #(.W(4)) u_sys_divn (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .en_in (div3_pulse),
    .ratio (4'h1 << cfg_r.sysclk_divide_sel), // R5 R9 R11
    .pulse (sysdiv_pulse)
  );

  // ----------------------------------------------------------------
  // Clock enables and secondary oscillator
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cur_osc_r)
      OSC_FAST_RC_MULT,
      OSC_PRIMARY_MULT: sys_tick = USB_VARIANT ? sysdiv_pulse : mult_tick;
      OSC_PRIMARY:      sys_tick = pri_edge;
      OSC_FAST_RC,
      OSC_FAST_RC_DIV:  sys_tick = frc_edge;
      default:          sys_tick = 1'b0;
    endcase
    mult_en_nxt  = mult_tick;
    usb_en_nxt   = USB_VARIANT && usb_pulse && cur_osc_r == OSC_PRIMARY_MULT; // R4 R12
    sys_en_nxt   = sys_tick;
    instr_ph_nxt = instr_ph_r ^ sys_tick;
    instr_en_nxt = sys_tick && instr_ph_r; // R9
    secondary_32k_osc_run_nxt = lposc_en_r || (cur_osc_r == OSC_SECONDARY && !SLEEP); // R20 R21 R22
  end

  // ----------------------------------------------------------------
  // Registers and lock flag
  // ----------------------------------------------------------------
  always_comb begin
    cur_osc_nxt  = cur_osc_r;
    new_osc_nxt  = new_osc_r;
    lposc_en_nxt = lposc_en_r;
    cfg_nxt      = cfg_r;
    key_seen_nxt = 1'b0;
    unlocked_nxt = unlocked_r;
    rdata_nxt    = '0;
    if (WR) begin
      unique case (ADDR)
        OFF_UNLOCK: begin
          key_seen_nxt = (WDATA == UNLOCK_KEY1);
          if (key_seen_r && WDATA == UNLOCK_KEY2) begin
            unlocked_nxt = 1'b1; // R19
          end
        end
        OFF_CFG: begin
          cfg_nxt.usb_active            = WDATA[USB_ACT_BIT];
          cfg_nxt.mult_input_divide_sel = WDATA[MULT_DIV_LSB +: 3];
          cfg_nxt.fast_rc_postscale_sel = WDATA[RC_POST_LSB +: 3];
          cfg_nxt.sysclk_divide_sel     = WDATA[SYS_DIV_LSB +: 2];
        end
        OFF_OSC_CTRL: begin
          if (unlocked_r) begin // R19
            unlocked_nxt = 1'b0;
            new_osc_nxt  = WDATA[NEW_OSC_LSB +: 3];
            lposc_en_nxt = WDATA[LPOSC_EN_BIT]; // R18
            if (WDATA[SWITCH_BIT]) begin
              cur_osc_nxt = osc_sel_t'(WDATA[NEW_OSC_LSB +: 3]);
            end
          end
        end
        default: ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        OFF_OSC_CTRL: begin
          rdata_nxt[CUR_OSC_LSB +: 3] = cur_osc_r;
          rdata_nxt[NEW_OSC_LSB +: 3] = new_osc_r;
          rdata_nxt[LOCK_BIT]         = LOCK; // R15
          rdata_nxt[LPOSC_EN_BIT]     = lposc_en_r;
        end
        OFF_CFG: begin
          rdata_nxt[USB_ACT_BIT]         = cfg_r.usb_active;
          rdata_nxt[MULT_DIV_LSB +: 3]   = cfg_r.mult_input_divide_sel;
          rdata_nxt[RC_POST_LSB +: 3]    = cfg_r.fast_rc_postscale_sel;
          rdata_nxt[SYS_DIV_LSB +: 2]    = cfg_r.sysclk_divide_sel;
        end
        default: rdata_nxt = '0;
      endcase
    end
    // Timer based only: once set, nothing but a restart or leaving the
    // multiplier clears it, so a real loss of lock goes unseen
    if (restart || src_now == SRC_NONE) begin
      lock_nxt = 1'b0; // R16
    end else begin
      lock_nxt = LOCK || lock_done; // R15 R17
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pri_s1_r        <= 1'b0;
      pri_s2_r        <= 1'b0;
      pri_s3_r        <= 1'b0;
      frc_s1_r        <= 1'b0;
      frc_s2_r        <= 1'b0;
      frc_s3_r        <= 1'b0;
      cur_osc_r       <= INIT_OSC;
      new_osc_r       <= INIT_OSC;
      lposc_en_r      <= 1'b0;
      cfg_r           <= CFG_RESET;
      key_seen_r      <= 1'b0;
      unlocked_r      <= 1'b0;
      src_r           <= SRC_NONE;
      pend_r          <= 6'h00;
      instr_ph_r      <= 1'b0;
      RDATA           <= '0;
      LOCK            <= 1'b0; // R16
      MULT_READY      <= 1'b0;
      SECONDARY_32K_OSC_RUN        <= 1'b0;
      SECONDARY_32K_OSC_PINS_OWNED <= 1'b0;
      MULT_CLK_EN     <= 1'b0;
      USB_CLK_EN      <= 1'b0;
      SYS_CLK_EN      <= 1'b0;
      INSTR_CLK_EN    <= 1'b0;
    end else begin
      pri_s1_r        <= PRI_OSC_IN;
      pri_s2_r        <= pri_s1_r;
      pri_s3_r        <= pri_s2_r;
      frc_s1_r        <= FRC_OSC_IN;
      frc_s2_r        <= frc_s1_r;
      frc_s3_r        <= frc_s2_r;
      cur_osc_r       <= cur_osc_nxt;
      new_osc_r       <= new_osc_nxt;
      lposc_en_r      <= lposc_en_nxt;
      cfg_r           <= cfg_nxt;
      key_seen_r      <= key_seen_nxt;
      unlocked_r      <= unlocked_nxt;
      src_r           <= src_now;
      pend_r          <= pend_nxt;
      instr_ph_r      <= instr_ph_nxt;
      RDATA           <= rdata_nxt;
      LOCK            <= lock_nxt;
      MULT_READY      <= ready_done && src_now != SRC_NONE && !restart; // R2
      SECONDARY_32K_OSC_RUN        <= secondary_32k_osc_run_nxt;
      SECONDARY_32K_OSC_PINS_OWNED <= lposc_en_r; // R18
      MULT_CLK_EN     <= mult_en_nxt;
      USB_CLK_EN      <= usb_en_nxt;
      SYS_CLK_EN      <= sys_en_nxt;
      INSTR_CLK_EN    <= instr_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_lock_switch_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R16
    sw_to_mult |=> !LOCK [*2]) else $error("Lock not cleared on switch to multiplier");
  a_lock_no_mult: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R16
    src_r == SRC_NONE && $past(src_r) == SRC_NONE |-> !LOCK)
    else $error("Lock set without multiplier source");
  a_lock_needs_timer: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R15
    $rose(LOCK) |-> $past(lock_done)) else $error("Lock set before lock delay");
  a_secondary_32k_osc_enabled_run: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R20
    lposc_en_r |=> SECONDARY_32K_OSC_RUN && SECONDARY_32K_OSC_PINS_OWNED) else $error("Secondary osc not running");
  a_secondary_32k_osc_sleep_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R22
    !lposc_en_r && SLEEP |=> !SECONDARY_32K_OSC_RUN) else $error("Secondary osc runs in sleep");
  a_secondary_32k_osc_intermittent: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R21
    !lposc_en_r && cur_osc_r != OSC_SECONDARY |=> !SECONDARY_32K_OSC_RUN)
    else $error("Secondary osc runs while unselected");
  a_locked_write_drop: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R19
    WR && ADDR == OFF_OSC_CTRL && !unlocked_r |=> $stable(lposc_en_r) && $stable(cur_osc_r))
    else $error("Control write taken without unlock");
  a_usb_primary_only: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R12
    USB_CLK_EN |-> $past(cur_osc_r) == OSC_PRIMARY_MULT) else $error("USB clock from wrong source");
  a_ready_gates_mult: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R2
    restart |=> !MULT_CLK_EN [*2]) else $error("Multiplier output before ready");
  a_mult_factor: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R3
    ref_tick && pend_r == 6'h00 |=> pend_r == (USB_VARIANT ? USB_FACTOR : BASIC_FACTOR))
    else $error("Wrong multiplication factor");
  a_lock_readback: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R15
    RD && ADDR == OFF_OSC_CTRL |=> RDATA[LOCK_BIT] == $past(LOCK)) else $error("Lock readback wrong");
endmodule

// >>> logic/clk_ctrl_pkg.sv
// Shared constants, types and helpers for the multiplier branch clock control
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and bus
  // ----------------------------------------------------------------
  localparam int          SYS_CLK_MHZ = 200;
  localparam int          ADDR_W      = 2;
  localparam int          DATA_W      = 16;
  localparam int          TIMER_W     = 16;

  localparam logic [1:0]  OFF_OSC_CTRL = 2'h0;
  localparam logic [1:0]  OFF_CFG      = 2'h1;
  localparam logic [1:0]  OFF_UNLOCK   = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CUR_OSC_LSB  = 12;
  localparam int          NEW_OSC_LSB  = 8;
  localparam int          LOCK_BIT     = 5;
  localparam int          LPOSC_EN_BIT = 1;
  localparam int          SWITCH_BIT   = 0;
  localparam int          USB_ACT_BIT  = 15;
  localparam int          MULT_DIV_LSB = 12;
  localparam int          RC_POST_LSB  = 8;
  localparam int          SYS_DIV_LSB  = 6;

  // Key values are arbitrary
  localparam logic [15:0] UNLOCK_KEY1  = 16'h00c3;
  localparam logic [15:0] UNLOCK_KEY2  = 16'h003c;

  // ----------------------------------------------------------------
  // Ratios and timing
  // ----------------------------------------------------------------
  localparam logic [5:0]  BASIC_FACTOR = 6'h04;
  localparam logic [5:0]  USB_FACTOR   = 6'h18;
  localparam logic [1:0]  USB_BRANCH_DIV = 2'h2;
  localparam logic [1:0]  SYS_BRANCH_DIV = 2'h3;
  localparam int          READY_NS_DEF = 1000;
  localparam int          LOCK_NS_DEF  = 2000;

  typedef enum logic [2:0] {
    OSC_FAST_RC      = 3'b000,
    OSC_FAST_RC_MULT = 3'b001,
    OSC_PRIMARY      = 3'b010,
    OSC_PRIMARY_MULT = 3'b011,
    OSC_SECONDARY    = 3'b100,
    OSC_LOW_RC       = 3'b101,
    OSC_RESERVED     = 3'b110,
    OSC_FAST_RC_DIV  = 3'b111
  } osc_sel_t;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_PRIMARY = 2'b01,
    SRC_FAST_RC = 2'b10
  } mult_src_t;

  typedef struct packed {
    logic       usb_active;
    logic [2:0] mult_input_divide_sel;
    logic [2:0] fast_rc_postscale_sel;
    logic [1:0] sysclk_divide_sel;
  } cfg_t;

  localparam cfg_t        CFG_RESET    = '0;

  function automatic logic [3:0] prescale_ratio(input logic [2:0] sel);
    case (sel)
      3'b000:  prescale_ratio = 4'h1;
      3'b001:  prescale_ratio = 4'h2;
      3'b010:  prescale_ratio = 4'h3;
      3'b011:  prescale_ratio = 4'h4;
      3'b100:  prescale_ratio = 4'h5;
      3'b101:  prescale_ratio = 4'h6;
      3'b110:  prescale_ratio = 4'ha;
      default: prescale_ratio = 4'hc;
    endcase
  endfunction

endpackage

// >>> logic/pulse_divider.sv
// Divides a stream of enable pulses by a run-time ratio
`timescale 1ns/1ps
module pulse_divider #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en_in,
  input  wire logic [W-1:0] ratio,
  output logic              pulse
);
  if (W < 1) begin : g_chk
    $error("pulse_divider needs W of at least 1");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         pulse_nxt;

  // Ratio 0 behaves as ratio 1 so a bad setting cannot freeze the chain
  always_comb begin
    cnt_nxt   = cnt_r;
    pulse_nxt = 1'b0;
    if (en_in) begin
      if (cnt_r + W'(1) >= ratio) begin
        cnt_nxt   = '0;
        pulse_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pulse <= pulse_nxt;
    end
  end
endmodule

// >>> logic/interval_timer.sv
// Restartable interval timer that raises done after a set number of cycles
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  if (W < 2) begin : g_chk
    $error("interval_timer needs W of at least 2");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = done;
    if (restart) begin
      cnt_nxt  = '0;
      done_nxt = 1'b0;
    end else if (!done) begin
      cnt_nxt  = cnt_r + W'(1);
      done_nxt = (cnt_r + W'(1) >= limit);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done  <= done_nxt;
    end
  end
endmodule

// >>> verification/osc_source_model.sv
// Free-running primary and fast RC oscillator stand-in
`timescale 1ns/1ps
module osc_source_model (
  input  wire logic       clk,
  input  wire logic [7:0] half,
  output logic            pri,
  output logic            fast_internal_rc_osc
);
  int pc = 0;
  int fc = 0;
  initial {pri, fast_internal_rc_osc} = 2'b00;
  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  // Primary period stays at or above 24 cycles so the tick queue never overruns
  always @(posedge clk) begin
    pc <= (pc + 1 >= int'(half)) ? 0 : pc + 1;
    if (pc + 1 >= int'(half)) pri <= ~pri;
    fc <= (fc == 15) ? 0 : fc + 1;
    if (fc == 15) fast_internal_rc_osc <= ~fast_internal_rc_osc;
  end
endmodule

// >>> verification/pll_branch_and_low_power_osc_ctrl_test.sv
// Self-checking bench for the multiplier branch clock control
`timescale 1ns/1ps
module pll_branch_and_low_power_osc_ctrl_test;
  import clk_ctrl_pkg::*;
  logic              clk, rst_n, wr, rd, pri, fast_internal_rc_osc, sleep;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic              secondary_32k_osc_run, pins, mclk, uclk, sclk, iclk, lock, mready, mclk_b;
  logic [7:0]        half;
  logic [1:0]        sd;
  int                bad_count, n_tests, seed, e, m, u, sy, ins, mb, off;
  int                rt[8] = '{1, 2, 3, 4, 5, 6, 10, 12};

  pll_branch_ctrl #(.READY_NS(50), .LOCK_NS(50)) pll_branch_ctrl_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PRI_OSC_IN(pri), .FRC_OSC_IN(fast_internal_rc_osc), .SLEEP(sleep),
    .SECONDARY_32K_OSC_RUN(secondary_32k_osc_run), .SECONDARY_32K_OSC_PINS_OWNED(pins), .MULT_CLK_EN(mclk),
    .USB_CLK_EN(uclk), .SYS_CLK_EN(sclk), .INSTR_CLK_EN(iclk), .LOCK(lock),
    .MULT_READY(mready));
  // Basic variant shares the bus, so it follows every switch
  pll_branch_ctrl #(.USB_VARIANT(1'b0), .READY_NS(50), .LOCK_NS(50)) pll_branch_ctrl_b_inst (
    .SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(), .PRI_OSC_IN(pri), .FRC_OSC_IN(fast_internal_rc_osc), .SLEEP(sleep), .SECONDARY_32K_OSC_RUN(),
    .SECONDARY_32K_OSC_PINS_OWNED(), .MULT_CLK_EN(mclk_b), .USB_CLK_EN(), .SYS_CLK_EN(),
    .INSTR_CLK_EN(), .LOCK(), .MULT_READY());
  osc_source_model osc_source_model_inst (.clk(clk), .half(half), .pri(pri), .fast_internal_rc_osc(fast_internal_rc_osc));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int exp_mult(input int ed, input int code);
    return ed * 24 / rt[code];
  endfunction
  function automatic logic [15:0] cw(input logic [2:0] o, input logic en, input logic sw);
    return {5'h00, o, 6'h00, en, sw};
  endfunction
  function automatic logic [15:0] cf(input logic us, input logic [2:0] md,
                                     input logic [2:0] ps, input logic [1:0] s);
    return {us, md, 1'b0, ps, s, 6'h00};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask
  task automatic near(input string nm, input int ex, input int got, input int tol);
    n_tests++;
    if (got > ex + tol || got + tol < ex) begin
      $display("wrong value %s expected %0d seen %0d", nm, ex, got);
      bad_count++;
    end
  endtask
  task automatic wrt(input logic [1:0] a, input logic [15:0] dd);
    @(posedge clk);
    addr <= a;
    wdata <= dd;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Keys must land on consecutive cycles, so the three writes run back to back
  task automatic ctl(input logic [15:0] dd);
    @(posedge clk);
    addr <= OFF_UNLOCK;
    wdata <= UNLOCK_KEY1;
    wr <= 1'b1;
    @(posedge clk);
    wdata <= UNLOCK_KEY2;
    @(posedge clk);
    addr <= OFF_OSC_CTRL;
    wdata <= dd;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic rdr(input logic [1:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic wait_lock;
    int k;
    for (k = 0; k < 200 && lock !== 1'b1; k++) @(negedge clk);
    chk("lock rise", 16'h0001, {15'h0000, lock});
    if (lock !== 1'b1) final_report;
  endtask
  task automatic cnt(input int n);
    logic p;
    p = pri;
    {e, m, u, sy, ins, mb} = '0;
    repeat (n) begin
      @(negedge clk);
      if (pri === 1'b1 && p === 1'b0) e++;
      p = pri;
      if (mclk === 1'b1) m++;
      if (uclk === 1'b1) u++;
      if (sclk === 1'b1) sy++;
      if (iclk === 1'b1) ins++;
      if (mclk_b === 1'b1) mb++;
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h5dd2;
    {bad_count, n_tests} = '0;
    {rst_n, wr, rd, sleep, addr, wdata} = '0;
    half = 8'h10;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("lock", 16'h0000, {15'h0000, lock});
    chk("secondary_32k_osc run", 16'h0000, {15'h0000, secondary_32k_osc_run});
    rdr(OFF_OSC_CTRL, d);
    chk("control", 16'h0000, d);
    rdr(2'h3, d);
    chk("unmapped", 16'h0000, d);
    wrt(OFF_OSC_CTRL, 16'($random(seed)) | 16'h0003);
    rdr(OFF_OSC_CTRL, d);
    chk("control no unlock", 16'h0000, d);
    chk("pins", 16'h0000, {15'h0000, pins});
    cnt(200);
    near("fast rc sys ticks", 6, sy, 1);
    wrt(OFF_CFG, cf(1'b1, 3'h0, 3'h0, 2'h0));
    ctl(cw(OSC_PRIMARY_MULT, 1'b1, 1'b1));
    chk("lock after switch", 16'h0000, {15'h0000, lock});
    chk("secondary_32k_osc run", 16'h0001, {15'h0000, secondary_32k_osc_run});
    chk("pins", 16'h0001, {15'h0000, pins});
    wait_lock;
    rdr(OFF_OSC_CTRL, d);
    chk("control", 16'h3322, d);
    repeat (20) @(negedge clk);
    chk("ready", 16'h0001, {15'h0000, mready});
    off = $random(seed) & 3;
    for (int i = 0; i < 8; i++) begin
      sd = 2'((i + off) % 4);
      half <= 8'h0d + 8'($unsigned($random(seed)) % 8);
      wrt(OFF_CFG, cf(sd < 2'h2, 3'(i), 3'h0, sd));
      repeat (80) @(negedge clk);
      cnt(6000);
      near("mult ticks", exp_mult(e, i), m, 36);
      near("usb ticks", m, 2 * u, 2);
      near("sys ticks", m, 3 * (1 << sd) * sy, 6 << sd);
      near("instr ticks", sy, 2 * ins, 2);
      if (i == 0) near("basic ticks", 4 * e, mb, 8);
    end
    wrt(OFF_CFG, cf(1'b0, 3'h0, 3'h0, 2'h0));
    ctl(cw(OSC_FAST_RC_MULT, 1'b1, 1'b1));
    chk("lock on source change", 16'h0000, {15'h0000, lock});
    wait_lock;
    cnt(600);
    chk("usb on fast rc", 16'h0000, 16'(u));
    near("fast rc ticks", 450, m, 48);
    wrt(OFF_CFG, cf(1'b0, 3'h0, 3'h2, 2'h0));
    repeat (40) @(negedge clk);
    cnt(200);
    chk("lock bad postscale", 16'h0000, {15'h0000, lock});
    chk("ticks bad postscale", 16'h0000, 16'(m));
    ctl(cw(OSC_PRIMARY, 1'b0, 1'b1));
    repeat (40) @(negedge clk);
    chk("lock primary", 16'h0000, {15'h0000, lock});
    chk("ready primary", 16'h0000, {15'h0000, mready});
    chk("secondary_32k_osc off", 16'h0000, {15'h0000, secondary_32k_osc_run});
    chk("pins released", 16'h0000, {15'h0000, pins});
    cnt(400);
    near("primary sys ticks", e, sy, 1);
    ctl(cw(OSC_SECONDARY, 1'b0, 1'b1));
    chk("secondary_32k_osc selected", 16'h0001, {15'h0000, secondary_32k_osc_run});
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(negedge clk);
    chk("secondary_32k_osc in sleep", 16'h0000, {15'h0000, secondary_32k_osc_run});
    ctl(cw(OSC_SECONDARY, 1'b1, 1'b0));
    chk("secondary_32k_osc enabled sleep", 16'h0001, {15'h0000, secondary_32k_osc_run});
    final_report;
  end
endmodule
